/* File: design/serial_config_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package serial_config_pkg;
    // register indices; byte address on apb is four times the index
    localparam logic [2:0] IDX_DEVICE_ID = 3'h0;
    localparam logic [2:0] IDX_RESET = 3'h1;
    localparam logic [2:0] IDX_MODE = 3'h2;
    localparam logic [2:0] IDX_ALIAS = 3'h3;
    localparam logic [2:0] IDX_ALIAS_TARGET = 3'h4;
    localparam logic [2:0] IDX_STATUS = 3'h5;
    localparam logic [2:0] IDX_LAST = 3'h5;

    localparam int DEVID_OVERRIDE_BIT = 0;
    localparam int RESET_LOGIC_BIT = 0;
    localparam int RESET_ALL_BIT = 1;
    localparam int RESET_AUTO_PD_BIT = 7;
    localparam int MODE_LEGACY_BIT = 0;
    localparam int MODE_LOWFREQ_BIT = 1;
    localparam int MODE_COLOR_MAP_BIT = 2;
    localparam int MODE_REPEATER_BIT = 3;
    localparam int ALIAS_EN_BIT = 0;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    localparam logic [6:0] ADDR_BAND_ZERO = 7'h0c;
    localparam logic [6:0] ADDR_BAND_BASE = 7'h12;
    localparam logic [3:0] ADDR_BAND_LAST = 4'h9;

    localparam logic [2:0] LINE_MULT_NORMAL = 3'h1;
    localparam logic [2:0] LINE_MULT_LOWFREQ = 3'h4;
    localparam logic [4:0] FRAME_BITS = 5'h1c;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } i2c_state_e;
endpackage : serial_config_pkg

/* File: design/serial_control_and_mode_config.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module serial_control_and_mode_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n,
    input wire logic power_down_n,
    input wire logic legacy_link_select,
    input wire logic low_freq_select,
    input wire logic color_map_select,
    input wire logic repeater_select,
    input wire logic [3:0] address_strap,
    input wire logic lvds_clock_in,
    input wire logic interrupt_in_n,
    output logic interrupt_out_n,
    output logic powered_down,
    output logic logic_reset,
    output logic legacy_active,
    output logic control_channel_enable,
    output logic gpio_enable,
    output logic audio_enable,
    output logic [2:0] line_rate_mult,
    output logic [4:0] frame_bits,
    output logic color_map_msb,
    output logic pixel_frame_ok,
    output logic fwd_active,
    output logic [6:0] fwd_target,
    output logic fwd_valid,
    output logic [7:0] fwd_byte
);

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic scl_q;
    logic sda_q;
    logic pd_q;
    logic lvds_q;

    // power-down bit resets low: straps are taken only once real pin values reach sync2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 13'h1bff;
            sync2 <= 13'h1bff;
        end else begin
            sync1 <= {scl_in, sda_in, power_down_n, repeater_select, color_map_select,
                      low_freq_select, legacy_link_select, lvds_clock_in, interrupt_in_n, address_strap};
            sync2 <= sync1;
        end
    end

    wire logic scl_s = sync2[12];
    wire logic sda_s = sync2[11];
    wire logic pd_s = sync2[10];
    wire logic [3:0] pin_modes = sync2[9:6];
    wire logic lvds_s = sync2[5];
    wire logic int_in_s = sync2[4];
    wire logic [3:0] strap_s = sync2[3:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            pd_q <= 1'b0;
            lvds_q <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            pd_q <= pd_s;
            lvds_q <= lvds_s;
        end
    end

    // edge of released power-down; pd_q starts low so a high pin at reset also counts
    wire logic pd_release = pd_s & ~pd_q;
    wire logic scl_rise = scl_s & ~scl_q;
    wire logic scl_fall = ~scl_s & scl_q;
    wire logic bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire logic bus_stop = scl_s & scl_q & ~sda_q & sda_s;

    //////////////////////////////////////////////////////////////////////////
    // resets
    logic reset_all_pulse;
    logic reset_logic_pulse;
    wire logic regs_clear = ~pd_s | reset_all_pulse;
    wire logic logic_clear = regs_clear | reset_logic_pulse;

    //////////////////////////////////////////////////////////////////////////
    // register file
    logic [6:0] dev_id_bits;
    logic dev_id_override;
    logic auto_pd;
    logic [7:0] mode_reg;
    logic [7:0] alias_reg;
    logic [6:0] alias_target;
    logic [3:0] strap_band;
    logic i2c_busy;

    logic i2c_wr;
    logic [7:0] i2c_ptr;
    logic [7:0] i2c_wdata;

    wire logic apb_mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) && (paddr[4:2] <= serial_config_pkg::IDX_LAST);
    wire logic apb_wr = psel & penable & pwrite & apb_mapped;
    // apb has priority; a same-cycle bus write is the one dropped
    wire logic wr_en = apb_wr | (i2c_wr & (i2c_ptr <= {5'h00, serial_config_pkg::IDX_LAST}));
    wire logic [2:0] wr_idx = apb_wr ? paddr[4:2] : i2c_ptr[2:0];
    wire logic [7:0] wr_data = apb_wr ? pwdata[7:0] : i2c_wdata;

    // strap band to address, bands past the last clamp to it
    logic [6:0] strap_addr;
    always_comb begin
        if (strap_band == 4'h0) begin
            strap_addr = serial_config_pkg::ADDR_BAND_ZERO;
        end else if (strap_band > serial_config_pkg::ADDR_BAND_LAST) begin
            strap_addr = serial_config_pkg::ADDR_BAND_BASE + {3'h0, serial_config_pkg::ADDR_BAND_LAST};
        end else begin
            strap_addr = serial_config_pkg::ADDR_BAND_BASE + {3'h0, strap_band};
        end
    end

    wire logic [6:0] own_addr = dev_id_override ? dev_id_bits : strap_addr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_band <= 4'h0;
        end else if (pd_release) begin
            strap_band <= strap_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_id_bits <= 7'h00;
            dev_id_override <= 1'b0;
        end else if (regs_clear) begin
            dev_id_bits <= 7'h00;
            dev_id_override <= 1'b0;
        end else if (wr_en && wr_idx == serial_config_pkg::IDX_DEVICE_ID) begin
            dev_id_override <= wr_data[serial_config_pkg::DEVID_OVERRIDE_BIT];
            // address bits only take a write that also sets override
            if (wr_data[serial_config_pkg::DEVID_OVERRIDE_BIT]) begin
                dev_id_bits <= wr_data[7:1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_pd <= 1'b0;
            reset_all_pulse <= 1'b0;
            reset_logic_pulse <= 1'b0;
        end else begin
            reset_all_pulse <= 1'b0;
            reset_logic_pulse <= 1'b0;
            if (regs_clear) begin
                auto_pd <= 1'b0;
            end else if (wr_en && wr_idx == serial_config_pkg::IDX_RESET) begin
                auto_pd <= wr_data[serial_config_pkg::RESET_AUTO_PD_BIT];
                reset_all_pulse <= wr_data[serial_config_pkg::RESET_ALL_BIT];
                reset_logic_pulse <= wr_data[serial_config_pkg::RESET_LOGIC_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= serial_config_pkg::REG_RESET_VALUE;
        end else if (pd_release) begin
            mode_reg <= {4'h0, pin_modes};
        end else if (regs_clear) begin
            mode_reg <= serial_config_pkg::REG_RESET_VALUE;
        end else if (wr_en && wr_idx == serial_config_pkg::IDX_MODE) begin
            mode_reg <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alias_reg <= serial_config_pkg::REG_RESET_VALUE;
            alias_target <= 7'h00;
        end else if (regs_clear) begin
            alias_reg <= serial_config_pkg::REG_RESET_VALUE;
            alias_target <= 7'h00;
        end else if (wr_en && wr_idx == serial_config_pkg::IDX_ALIAS) begin
            alias_reg <= wr_data;
        end else if (wr_en && wr_idx == serial_config_pkg::IDX_ALIAS_TARGET) begin
            alias_target <= wr_data[7:1];
        end
    end

    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        case (idx)
            {5'h00, serial_config_pkg::IDX_DEVICE_ID}: read_reg = {own_addr, dev_id_override};
            {5'h00, serial_config_pkg::IDX_RESET}: read_reg = {auto_pd, 7'h00};
            {5'h00, serial_config_pkg::IDX_MODE}: read_reg = mode_reg;
            {5'h00, serial_config_pkg::IDX_ALIAS}: read_reg = alias_reg;
            {5'h00, serial_config_pkg::IDX_ALIAS_TARGET}: read_reg = {alias_target, 1'b0};
            {5'h00, serial_config_pkg::IDX_STATUS}: read_reg = {strap_band, pixel_frame_ok, i2c_busy, 2'h0};
            default: read_reg = 8'h00;
        endcase
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // apb slave, no wait states; read data captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~apb_mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, read_reg({5'h00, paddr[4:2]})};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // serial control bus target; never stretches scl
    serial_config_pkg::i2c_state_e state;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [3:0] bit_cnt;
    logic is_read;
    logic first_byte;
    logic host_ack;
    logic fwd_hit;

    wire logic [6:0] rx_addr = rx_shift[7:1];
    wire logic alias_hit = mode_reg[serial_config_pkg::MODE_REPEATER_BIT] & alias_reg[serial_config_pkg::ALIAS_EN_BIT]
                           & (rx_addr == alias_reg[7:1]);
    wire logic own_hit = (rx_addr == own_addr);
    wire logic [7:0] ptr_data = read_reg(i2c_ptr);

    assign sda_out = 1'b0;
    assign i2c_busy = (state != serial_config_pkg::ST_IDLE);
    assign fwd_target = alias_target;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= serial_config_pkg::ST_IDLE;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            bit_cnt <= 4'h0;
            is_read <= 1'b0;
            first_byte <= 1'b0;
            host_ack <= 1'b0;
            fwd_hit <= 1'b0;
            sda_drive_n <= 1'b1;
            i2c_ptr <= 8'h00;
            i2c_wr <= 1'b0;
            i2c_wdata <= 8'h00;
            fwd_valid <= 1'b0;
            fwd_byte <= 8'h00;
        end else begin
            i2c_wr <= 1'b0;
            fwd_valid <= 1'b0;
            if (logic_clear) begin
                state <= serial_config_pkg::ST_IDLE;
                sda_drive_n <= 1'b1;
                fwd_hit <= 1'b0;
                if (regs_clear) begin
                    i2c_ptr <= 8'h00;
                end
            end else if (bus_start) begin
                state <= serial_config_pkg::ST_ADDR;
                bit_cnt <= 4'h0;
                first_byte <= 1'b1;
                fwd_hit <= 1'b0;
                sda_drive_n <= 1'b1;
            end else if (bus_stop) begin
                state <= serial_config_pkg::ST_IDLE;
                sda_drive_n <= 1'b1;
                fwd_hit <= 1'b0;
            end else begin
                case (state)
                    serial_config_pkg::ST_ADDR: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (own_hit || alias_hit) begin
                                sda_drive_n <= 1'b0;
                                is_read <= rx_shift[0];
                                fwd_hit <= alias_hit & ~own_hit;
                                state <= serial_config_pkg::ST_ADDR_ACK;
                            end else begin
                                state <= serial_config_pkg::ST_IDLE;
                            end
                        end
                    end
                    serial_config_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (is_read) begin
                                // forwarded reads have no local data: all ones
                                tx_shift <= fwd_hit ? 8'hff : ptr_data;
                                sda_drive_n <= fwd_hit | ptr_data[7];
                                i2c_ptr <= i2c_ptr + 8'h01;
                                state <= serial_config_pkg::ST_READ;
                            end else begin
                                sda_drive_n <= 1'b1;
                                state <= serial_config_pkg::ST_WRITE;
                            end
                        end
                    end
                    serial_config_pkg::ST_WRITE: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            sda_drive_n <= 1'b0;
                            state <= serial_config_pkg::ST_WRITE_ACK;
                            if (fwd_hit) begin
                                fwd_valid <= 1'b1;
                                fwd_byte <= rx_shift;
                            end else if (first_byte) begin
                                i2c_ptr <= rx_shift;
                                first_byte <= 1'b0;
                            end else begin
                                i2c_wr <= 1'b1;
                                i2c_wdata <= rx_shift;
                            end
                        end
                    end
                    serial_config_pkg::ST_WRITE_ACK: begin
                        if (i2c_wr) begin
                            i2c_ptr <= i2c_ptr + 8'h01;
                        end
                        if (scl_fall) begin
                            sda_drive_n <= 1'b1;
                            bit_cnt <= 4'h0;
                            state <= serial_config_pkg::ST_WRITE;
                        end
                    end
                    serial_config_pkg::ST_READ: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h7) begin
                                sda_drive_n <= 1'b1;
                                state <= serial_config_pkg::ST_READ_ACK;
                            end else begin
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                sda_drive_n <= tx_shift[6];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    serial_config_pkg::ST_READ_ACK: begin
                        if (scl_rise) begin
                            host_ack <= ~sda_s;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (host_ack) begin
                                tx_shift <= fwd_hit ? 8'hff : ptr_data;
                                sda_drive_n <= fwd_hit | ptr_data[7];
                                i2c_ptr <= i2c_ptr + 8'h01;
                                state <= serial_config_pkg::ST_READ;
                            end else begin
                                state <= serial_config_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= serial_config_pkg::ST_IDLE;
                        sda_drive_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pixel clock shape check: high share must exceed low share (4:3)
    logic [3:0] hi_cnt;
    logic [3:0] lo_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 4'h0;
            lo_cnt <= 4'h0;
            pixel_frame_ok <= 1'b0;
        end else if (logic_clear) begin
            hi_cnt <= 4'h0;
            lo_cnt <= 4'h0;
            pixel_frame_ok <= 1'b0;
        end else if (lvds_s && !lvds_q) begin
            pixel_frame_ok <= (hi_cnt > lo_cnt) && (lo_cnt != 4'h0);
            hi_cnt <= 4'h1;
            lo_cnt <= 4'h0;
        end else if (lvds_s) begin
            // saturate so a stopped clock cannot wrap into a false pass
            hi_cnt <= (hi_cnt == 4'hf) ? hi_cnt : hi_cnt + 4'h1;
        end else begin
            lo_cnt <= (lo_cnt == 4'hf) ? lo_cnt : lo_cnt + 4'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // mode outputs to the datapath
    wire logic legacy = mode_reg[serial_config_pkg::MODE_LEGACY_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down <= 1'b1;
            logic_reset <= 1'b1;
            legacy_active <= 1'b0;
            control_channel_enable <= 1'b0;
            gpio_enable <= 1'b0;
            audio_enable <= 1'b0;
            interrupt_out_n <= 1'b1;
            line_rate_mult <= serial_config_pkg::LINE_MULT_NORMAL;
            frame_bits <= serial_config_pkg::FRAME_BITS;
            color_map_msb <= 1'b0;
            fwd_active <= 1'b0;
        end else begin
            powered_down <= ~pd_s;
            logic_reset <= logic_clear;
            legacy_active <= legacy;
            control_channel_enable <= pd_s & ~legacy;
            gpio_enable <= pd_s & ~legacy;
            audio_enable <= pd_s & ~legacy;
            interrupt_out_n <= legacy | ~pd_s | int_in_s;
            if (!legacy && mode_reg[serial_config_pkg::MODE_LOWFREQ_BIT]) begin
                line_rate_mult <= serial_config_pkg::LINE_MULT_LOWFREQ;
            end else begin
                line_rate_mult <= serial_config_pkg::LINE_MULT_NORMAL;
            end
            frame_bits <= serial_config_pkg::FRAME_BITS;
            color_map_msb <= mode_reg[serial_config_pkg::MODE_COLOR_MAP_BIT];
            fwd_active <= fwd_hit;
        end
    end

endmodule : serial_control_and_mode_config
`default_nettype wire

/* File: dv/scmc_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module scmc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_down_n,
    input wire logic sda_drive_n,
    input wire logic powered_down,
    input wire logic legacy_active,
    input wire logic control_channel_enable,
    input wire logic gpio_enable,
    input wire logic interrupt_out_n,
    input wire logic [2:0] line_rate_mult,
    input wire logic [4:0] frame_bits,
    input wire logic fwd_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pin passes a 2-ff sync, so four low samples must reach the flag
    property p_pd; !power_down_n [*4] |-> powered_down; endproperty
    a_pd: assert property (p_pd) else $error("power down missed");
    property p_off; legacy_active || powered_down |-> !control_channel_enable && !gpio_enable; endproperty
    a_off: assert property (p_off) else $error("channel left on");
    property p_int; legacy_active |-> interrupt_out_n; endproperty
    a_int: assert property (p_int) else $error("interrupt in legacy");
    property p_lr; legacy_active |-> line_rate_mult == 3'h1; endproperty
    a_lr: assert property (p_lr) else $error("legacy rate changed");
    property p_lr4; line_rate_mult == 3'h1 || line_rate_mult == 3'h4; endproperty
    a_lr4: assert property (p_lr4) else $error("bad rate ratio");
    property p_fb; frame_bits == 5'h1c; endproperty
    a_fb: assert property (p_fb) else $error("bad frame size");
    property p_fwd; fwd_valid |=> !fwd_valid; endproperty
    a_fwd: assert property (p_fwd) else $error("forward pulse too long");
    property p_ack; $fell(sda_drive_n) |=> !sda_drive_n [*8]; endproperty
    a_ack: assert property (p_ack) else $error("sda drive too short");
    cover property (fwd_valid);
    cover property (!sda_drive_n);
    cover property (legacy_active);
endmodule : scmc_asserts
`default_nettype wire

/* File: dv/i2c_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
    input wire logic clk,
    input wire logic sda_line,
    input wire logic scl_line,
    output logic scl = 1'b1,
    output logic sda = 1'b1
);
    // sda 1 means released; the pull-up makes the line high
    task automatic drv(input logic c, input logic d);
        scl <= c;
        sda <= d;
        repeat (20) @(posedge clk);
        // a target may hold scl low; wait until the line really is high
        while (c && !scl_line) @(posedge clk);
    endtask : drv
    task automatic start(); drv(0, 1); drv(1, 1); drv(1, 0); drv(0, 0); endtask : start
    task automatic stop(); drv(0, 0); drv(1, 0); drv(1, 1); endtask : stop
    task automatic bit_x(input logic b, output logic r); drv(0, b); drv(1, b); r = sda_line; drv(0, b); endtask : bit_x
    // ai 0 acks a read byte, 1 ends the read
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(ai, ak);
    endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

/* File: dv/serial_control_and_mode_config_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_control_and_mode_config_bench;
    logic pclk, presetn, psel, penable, pwrite, power_down_n, lvds_clock_in, pready, sda_drive_n, sda_out;
    logic scl, sda, ak, legacy_active, color_map_msb, pixel_frame_ok, int_n, interrupt_out_n;
    logic [2:0] line_rate_mult;
    logic [3:0] address_strap, pins;
    logic [7:0] rb, fwd_byte;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int err_total, tests_run;
    wire sda_line = sda & (sda_drive_n | sda_out);
    serial_control_and_mode_config u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr(), .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_drive_n, .power_down_n,
        .legacy_link_select(pins[0]), .low_freq_select(pins[1]), .color_map_select(pins[2]),
        .repeater_select(pins[3]), .address_strap, .lvds_clock_in, .interrupt_in_n(int_n), .interrupt_out_n,
        .powered_down(), .logic_reset(), .legacy_active, .control_channel_enable(), .gpio_enable(),
        .audio_enable(), .line_rate_mult, .frame_bits(), .color_map_msb, .pixel_frame_ok, .fwd_active(),
        .fwd_target(), .fwd_valid(), .fwd_byte);
    i2c_host_model u_h (.clk(pclk), .sda_line, .scl_line(scl), .scl, .sda);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // 46/34 ns approximates the 4:3 high/low split of one pixel frame
    initial begin
        lvds_clock_in = 1'b0;
        #3;
        forever begin
            lvds_clock_in = 1'b1;
            #46 lvds_clock_in = 1'b0;
            #34;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // power-down held 8 cycles, not the full hold, to keep the run short
    task automatic pd(input logic [3:0] m, input logic [3:0] s);
        pins <= m; address_strap <= s; power_down_n <= 1'b0;
        repeat (8) @(posedge pclk);
        power_down_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : pd
    task automatic i2w(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, input logic e);
        u_h.start();
        u_h.xfer(a, 1'b1, rb, ak); chk(ak, e);
        u_h.xfer(p, 1'b1, rb, ak);
        u_h.xfer(d, 1'b1, rb, ak); chk(ak, e);
        u_h.stop();
    endtask : i2w
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        #600000;
        err_total++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pins, address_strap, int_n} = '0;
        presetn = 1'b0;
        power_down_n = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h008, 0); chk(q, 0);
        apb(0, 12'h004, 0); chk(q, 0);
        for (int b = 0; b < 10; b++) begin
            pd(4'h0, b[3:0]);
            apb(0, 12'h000, 0); chk(q, b == 0 ? 32'h18 : 32'h24 + 2 * b);
        end
        $display("strap test done");
        pd(4'hf, 4'h0);
        apb(0, 12'h008, 0); chk(q, 32'h0f);
        chk(legacy_active, 1'b1); chk(line_rate_mult, 3'h1); chk(color_map_msb, 1'b1);
        chk(interrupt_out_n, 1'b1);
        apb(1, 12'h008, 8'h02);
        repeat (4) @(posedge pclk);
        chk(legacy_active, 1'b0); chk(line_rate_mult, 3'h4);
        chk(interrupt_out_n, 1'b0);
        pd(4'h2, 4'h0);
        apb(0, 12'h008, 0); chk(q, 32'h02); chk(line_rate_mult, 3'h4);
        pd(4'h0, 4'h0);
        apb(0, 12'h008, 0); chk(q, 0);
        apb(1, 12'h008, 8'h04); apb(1, 12'h004, 8'h01);
        apb(0, 12'h008, 0); chk(q, 32'h04);
        apb(1, 12'h004, 8'h02);
        apb(0, 12'h008, 0); chk(q, 0);
        $display("mode test done");
        i2w(8'h18, 8'h02, 8'h05, 1'b0);
        apb(0, 12'h008, 0); chk(q, 32'h05);
        u_h.start(); u_h.xfer(8'h18, 1'b1, rb, ak); u_h.xfer(8'h02, 1'b1, rb, ak);
        u_h.start(); u_h.xfer(8'h19, 1'b1, rb, ak); u_h.xfer(8'hff, 1'b1, rb, ak);
        chk(rb, 8'h05);
        u_h.stop();
        i2w(8'h1a, 8'h02, 8'h00, 1'b1);
        apb(1, 12'h000, 8'h55); apb(0, 12'h000, 0); chk(q, 32'h55);
        i2w(8'h54, 8'h02, 8'h08, 1'b0);
        apb(1, 12'h00c, 8'h61);
        i2w(8'h60, 8'h33, 8'ha5, 1'b0); chk(fwd_byte, 8'ha5);
        $display("bus test done");
        chk(pixel_frame_ok, 1'b1);
        apb(0, 12'h014, 0); chk(q, 32'h08);
        $display("link test done");
        wrap_up();
    end
endmodule : serial_control_and_mode_config_bench
bind serial_control_and_mode_config scmc_asserts u_chk (.pclk, .presetn, .power_down_n, .sda_drive_n, .powered_down,
    .legacy_active, .control_channel_enable, .gpio_enable, .interrupt_out_n, .line_rate_mult, .frame_bits, .fwd_valid);
`default_nettype wire
